// ---- hdl/nv_access_pkg.sv ----
package nv_access_pkg;

  // ----------------------------------------
  // Register byte offsets (word aligned)
  // ----------------------------------------
  localparam int BUS_ADDR_W = 6;
  localparam logic [5:0] OFS_DATA_LOW = 6'h00;
  localparam logic [5:0] OFS_DATA_HIGH = 6'h04;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h08;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h0C;
  localparam logic [5:0] OFS_CONTROL = 6'h10;
  localparam logic [5:0] OFS_UNLOCK = 6'h14;
  localparam logic [5:0] OFS_IRQ_MASK_TWO = 6'h18;
  localparam logic [5:0] OFS_IRQ_FLAG_TWO = 6'h1C;
  localparam logic [5:0] OFS_IRQ_CONTROL = 6'h20;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTL_READ_BIT = 0;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_ABORT_BIT = 3;
  localparam int CTL_SPACE_BIT = 7;
  localparam int DONE_IRQ_BIT = 4;
  localparam int GATE_BIT = 6;
  localparam logic [7:0] MASK_IMPL = 8'hFD;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_ONE = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_TWO = 8'hAA;

  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int DATA_MEM_DEPTH = 256;
  localparam int PROG_MEM_DEPTH = 32768;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;

  // Self-write guard settings and protected upper bounds
  localparam logic [1:0] GUARD_OFF = 2'b11;
  localparam logic [1:0] GUARD_LOW = 2'b10;
  localparam logic [1:0] GUARD_HALF = 2'b01;
  localparam logic [14:0] GUARD_LOW_TOP = 15'h01FF;
  localparam logic [14:0] GUARD_HALF_TOP = 15'h0FFF;
  localparam logic [14:0] GUARD_ALL_TOP = 15'h1FFF;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_MHZ = 20;
  localparam int ERASE_TIME_NS = 2000;
  localparam int PROGRAM_TIME_NS = 2000;
  localparam int ERASE_CYCLES_RAW = (ERASE_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int PROGRAM_CYCLES_RAW = (PROGRAM_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int ERASE_CYCLES = (ERASE_CYCLES_RAW < 1) ? 1 : ERASE_CYCLES_RAW;
  localparam int PROGRAM_CYCLES = (PROGRAM_CYCLES_RAW < 1) ? 1 : PROGRAM_CYCLES_RAW;
  localparam int TIMER_W = 8;

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_PROGRAM = 4'b1000
  } nv_state_type;

  typedef enum logic [2:0] {
    KEY_WAIT = 3'b001,
    KEY_HALF = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_type;

endpackage : nv_access_pkg

// ---- hdl/nv_memory_access_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module nv_memory_access_control
  import nv_access_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic por,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata_ff,
  output logic waitrequest_ff,
  output logic irq_ff,
  input wire logic [1:0] guard_pins,
  input wire logic code_protect_pin,
  input wire logic ext_read_req_pin,
  input wire logic ext_space_pin,
  input wire logic [14:0] ext_addr_pins,
  output logic [13:0] ext_rdata_ff,
  output logic ext_denied_ff,
  output logic ext_valid_ff
);

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [7:0] data_mem [DATA_MEM_DEPTH];
  logic [13:0] prog_mem [PROG_MEM_DEPTH];
  nv_state_type st_ff;
  key_state_type key_ff;
  logic [TIMER_W-1:0] timer_ff;
  logic [7:0] data_low_ff;
  logic [5:0] data_high_ff;
  logic [7:0] addr_low_ff;
  logic [6:0] addr_high_ff;
  logic space_ff;
  logic permit_ff;
  logic abort_ff;
  logic read_start_ff;
  logic write_start_ff;
  logic [7:0] irq_mask_ff;
  logic done_flag_ff;
  logic gate_ff;
  logic tgt_space_ff;
  logic [14:0] tgt_addr_ff;
  logic [13:0] tgt_data_ff;
  logic [19:0] pin_meta_ff;
  logic [19:0] pin_sync_ff;
  logic ext_req_prev_ff;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic bus_wr;
  logic lane0;
  logic ctl_wr;
  logic idle;
  logic rd_done;
  logic wr_done;
  logic [14:0] cur_addr;
  logic blocked;
  logic [1:0] guard_sync;
  logic cp_sync;
  logic ext_req_sync;
  logic ext_space_sync;
  logic [14:0] ext_addr_sync;
  logic [7:0] ctl_view;
  logic [31:0] nxt_readdata;

  // Access is taken in the cycle waitrequest is low
  assign bus_wr = write && !waitrequest_ff;
  assign lane0 = byteenable[0];
  assign ctl_wr = bus_wr && lane0 && (address == OFS_CONTROL);
  assign idle = (st_ff == ST_IDLE);
  assign rd_done = (st_ff == ST_READ);
  assign wr_done = (st_ff == ST_PROGRAM) && (timer_ff == '0);
  assign cur_addr = {addr_high_ff, addr_low_ff};
  assign {guard_sync, cp_sync, ext_req_sync, ext_space_sync, ext_addr_sync} = pin_sync_ff;
  assign ctl_view = {space_ff, 3'b000, abort_ff, permit_ff, write_start_ff, read_start_ff};

  // Guarded region check for program space writes
  function automatic logic guard_blocks(input logic [1:0] g, input logic [14:0] a);
    logic hit;
    hit = 1'b0;
    case (g)
      GUARD_OFF: hit = 1'b0;
      GUARD_LOW: hit = (a <= GUARD_LOW_TOP);
      GUARD_HALF: hit = (a <= GUARD_HALF_TOP);
      default: hit = (a <= GUARD_ALL_TOP);
    endcase
    return hit;
  endfunction : guard_blocks

  // Space bit carried by the start write counts, so a combined write cannot slip past
  assign blocked = (ctl_wr ? writedata[CTL_SPACE_BIT] : space_ff)
                   && guard_blocks(guard_sync, cur_addr);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Straps and programmer pins come from outside the clock domain
  always_ff @(posedge mclk) begin
    pin_meta_ff <= {guard_pins, code_protect_pin, ext_read_req_pin, ext_space_pin,
                    ext_addr_pins};
    pin_sync_ff <= pin_meta_ff;
  end

  // ----------------------------------------
  // Avalon slave handshake and read mux
  // ----------------------------------------
  // Unmapped and unlock addresses read zero
  always_comb begin
    nxt_readdata = 32'h00000000;
    case (address)
      OFS_DATA_LOW: nxt_readdata[7:0] = data_low_ff;
      OFS_DATA_HIGH: nxt_readdata[5:0] = data_high_ff;
      OFS_ADDR_LOW: nxt_readdata[7:0] = addr_low_ff;
      OFS_ADDR_HIGH: nxt_readdata[6:0] = addr_high_ff;
      OFS_CONTROL: nxt_readdata[7:0] = ctl_view;
      OFS_UNLOCK: nxt_readdata = 32'h00000000;
      OFS_IRQ_MASK_TWO: nxt_readdata[7:0] = irq_mask_ff;
      OFS_IRQ_FLAG_TWO: nxt_readdata[DONE_IRQ_BIT] = done_flag_ff;
      OFS_IRQ_CONTROL: nxt_readdata[GATE_BIT] = gate_ff;
      default: nxt_readdata = 32'h00000000;
    endcase
  end

  // One wait cycle per access; data registered in that cycle
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else begin
      waitrequest_ff <= !((read || write) && waitrequest_ff);
      if (read && waitrequest_ff) begin
        readdata_ff <= nxt_readdata;
      end
    end
  end

  // ----------------------------------------
  // Unlock key tracker
  // ----------------------------------------
  // Any other bus write disarms, so the key must come right before the start
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      key_ff <= KEY_WAIT;
    end else if (bus_wr && lane0 && address == OFS_UNLOCK) begin
      if (writedata[7:0] == UNLOCK_KEY_ONE) begin
        key_ff <= KEY_HALF;
      end else if (key_ff == KEY_HALF && writedata[7:0] == UNLOCK_KEY_TWO) begin
        key_ff <= KEY_ARMED;
      end else begin
        key_ff <= KEY_WAIT;
      end
    end else if (bus_wr) begin
      key_ff <= KEY_WAIT;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Abort flag is kept through a plain reset; only power-up or a control write clears it
  always_ff @(posedge mclk) begin
    if (por) begin
      space_ff <= 1'b0;
      permit_ff <= 1'b0;
      abort_ff <= 1'b0;
      read_start_ff <= 1'b0;
      write_start_ff <= 1'b0;
    end else if (reset) begin
      space_ff <= 1'b0;
      permit_ff <= 1'b0;
      read_start_ff <= 1'b0;
      write_start_ff <= 1'b0;
      if (st_ff == ST_ERASE || st_ff == ST_PROGRAM) begin
        abort_ff <= 1'b1;
      end
    end else begin
      if (rd_done) begin
        read_start_ff <= 1'b0;
      end else if (ctl_wr && idle && writedata[CTL_READ_BIT]) begin
        read_start_ff <= 1'b1;
      end
      if (wr_done) begin
        write_start_ff <= 1'b0;
      end else if (ctl_wr && idle && writedata[CTL_WRITE_BIT] && !writedata[CTL_READ_BIT]
                   && permit_ff && key_ff == KEY_ARMED && !blocked) begin
        write_start_ff <= 1'b1;
      end
      if (ctl_wr) begin
        permit_ff <= writedata[CTL_PERMIT_BIT];
        abort_ff <= writedata[CTL_ABORT_BIT];
        if (idle) begin
          space_ff <= writedata[CTL_SPACE_BIT];
        end
      end
    end
  end

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  // Read takes one cycle; write runs erase then program, each timed
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      st_ff <= ST_IDLE;
      timer_ff <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (read_start_ff) begin
            st_ff <= ST_READ;
          end else if (write_start_ff) begin
            st_ff <= ST_ERASE;
            timer_ff <= TIMER_W'(ERASE_CYCLES - 1);
          end
        end
        ST_READ: st_ff <= ST_IDLE;
        ST_ERASE: begin
          if (timer_ff == '0) begin
            st_ff <= ST_PROGRAM;
            timer_ff <= TIMER_W'(PROGRAM_CYCLES - 1);
          end else begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        ST_PROGRAM: begin
          if (timer_ff == '0) begin
            st_ff <= ST_IDLE;
          end else begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Target latched at start so register edits cannot disturb a write
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      tgt_space_ff <= 1'b0;
      tgt_addr_ff <= '0;
      tgt_data_ff <= '0;
    end else if (idle) begin
      tgt_space_ff <= space_ff;
      tgt_addr_ff <= space_ff ? cur_addr : {7'h00, addr_low_ff};
      tgt_data_ff <= space_ff ? {data_high_ff, data_low_ff} : {6'h00, data_low_ff};
    end
  end

  // ----------------------------------------
  // Memory arrays
  // ----------------------------------------
  // Erase lands at the end of the erase phase, new value at the end of programming
  always_ff @(posedge mclk) begin
    if (!reset && !por && st_ff == ST_ERASE && timer_ff == '0) begin
      if (tgt_space_ff) begin
        prog_mem[tgt_addr_ff] <= ERASED_WORD;
      end else begin
        data_mem[tgt_addr_ff[7:0]] <= ERASED_BYTE;
      end
    end else if (!reset && !por && wr_done) begin
      if (tgt_space_ff) begin
        prog_mem[tgt_addr_ff] <= tgt_data_ff;
      end else begin
        data_mem[tgt_addr_ff[7:0]] <= tgt_data_ff[7:0];
      end
    end
  end

  // ----------------------------------------
  // Data and address registers
  // ----------------------------------------
  // A finished read overrides a bus write in the same cycle
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      data_low_ff <= 8'h00;
      data_high_ff <= 6'h00;
    end else if (rd_done) begin
      if (tgt_space_ff) begin
        {data_high_ff, data_low_ff} <= prog_mem[tgt_addr_ff];
      end else begin
        data_low_ff <= data_mem[tgt_addr_ff[7:0]];
      end
    end else if (bus_wr && lane0) begin
      if (address == OFS_DATA_LOW) begin
        data_low_ff <= writedata[7:0];
      end
      if (address == OFS_DATA_HIGH) begin
        data_high_ff <= writedata[5:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || por) begin
      addr_low_ff <= 8'h00;
      addr_high_ff <= 7'h00;
    end else if (bus_wr && lane0) begin
      if (address == OFS_ADDR_LOW) begin
        addr_low_ff <= writedata[7:0];
      end
      if (address == OFS_ADDR_HIGH) begin
        addr_high_ff <= writedata[6:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status, mask, gate
  // ----------------------------------------
  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      done_flag_ff <= 1'b0;
    end else if (wr_done) begin
      done_flag_ff <= 1'b1;
    end else if (bus_wr && lane0 && address == OFS_IRQ_FLAG_TWO
                 && writedata[DONE_IRQ_BIT]) begin
      done_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || por) begin
      irq_mask_ff <= MASK_RESET;
      gate_ff <= 1'b0;
    end else if (bus_wr && lane0) begin
      if (address == OFS_IRQ_MASK_TWO) begin
        irq_mask_ff <= writedata[7:0] & MASK_IMPL;
      end
      if (address == OFS_IRQ_CONTROL) begin
        gate_ff <= writedata[GATE_BIT];
      end
    end
  end

  // Registered level output
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= gate_ff && irq_mask_ff[DONE_IRQ_BIT] && done_flag_ff;
    end
  end

  // ----------------------------------------
  // External programmer read port
  // ----------------------------------------
  // Only a rising request edge is served; protection answers zero plus denied
  always_ff @(posedge mclk) begin
    if (reset || por) begin
      ext_req_prev_ff <= 1'b0;
      ext_rdata_ff <= 14'h0000;
      ext_denied_ff <= 1'b0;
      ext_valid_ff <= 1'b0;
    end else begin
      ext_req_prev_ff <= ext_req_sync;
      ext_valid_ff <= ext_req_sync && !ext_req_prev_ff;
      if (ext_req_sync && !ext_req_prev_ff) begin
        ext_denied_ff <= cp_sync;
        if (cp_sync) begin
          ext_rdata_ff <= 14'h0000;
        end else if (ext_space_sync) begin
          ext_rdata_ff <= prog_mem[ext_addr_sync];
        end else begin
          ext_rdata_ff <= {6'h00, data_mem[ext_addr_sync[7:0]]};
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam int ERASE_SPAN = ERASE_CYCLES - 1;
  localparam int PROGRAM_SPAN = PROGRAM_CYCLES - 1;

  read_clear_a: assert property (@(posedge mclk) disable iff (reset || por)
    (st_ff == ST_READ) |=> !read_start_ff)
    else $error("read start not cleared after read");

  space_reset_a: assert property (@(posedge mclk)
    $past(reset) |-> !space_ff)
    else $error("space select not data after reset");

  permit_por_a: assert property (@(posedge mclk)
    $past(por) |-> !permit_ff && !write_start_ff)
    else $error("permit set after power-up");

  abort_keep_a: assert property (@(posedge mclk)
    (reset && !por && (st_ff == ST_ERASE || st_ff == ST_PROGRAM)) |=> abort_ff)
    else $error("abort flag missing after interrupted write");

  done_flag_a: assert property (@(posedge mclk) disable iff (reset || por)
    wr_done |=> done_flag_ff && idle)
    else $error("done flag not set at write end");

  unlock_zero_a: assert property (@(posedge mclk) disable iff (reset || por)
    (read && !waitrequest_ff && address == OFS_UNLOCK) |-> readdata_ff == 32'h00000000)
    else $error("unlock register read non-zero");

  mask_gate_a: assert property (@(posedge mclk) disable iff (reset || por)
    (!irq_mask_ff[DONE_IRQ_BIT] || !done_flag_ff) |=> !irq_ff)
    else $error("interrupt raised while masked");

  periph_gate_a: assert property (@(posedge mclk) disable iff (reset || por)
    !gate_ff |=> !irq_ff)
    else $error("interrupt raised with gate closed");

  erase_time_a: assert property (@(posedge mclk) disable iff (reset || por)
    $rose(st_ff == ST_ERASE) |-> ##ERASE_SPAN (st_ff == ST_ERASE) ##1 (st_ff == ST_PROGRAM))
    else $error("erase phase length wrong");

  program_time_a: assert property (@(posedge mclk) disable iff (reset || por)
    $rose(st_ff == ST_PROGRAM) |-> ##PROGRAM_SPAN (st_ff == ST_PROGRAM) ##1 idle)
    else $error("program phase length wrong");

  guard_block_a: assert property (@(posedge mclk) disable iff (reset || por)
    $rose(write_start_ff) |-> !$past(blocked))
    else $error("write started into guarded region");

  start_key_a: assert property (@(posedge mclk) disable iff (reset || por)
    $rose(write_start_ff) |-> $past(permit_ff) && $past(key_ff == KEY_ARMED))
    else $error("write started without permit and key");

  ext_deny_a: assert property (@(posedge mclk) disable iff (reset || por)
    (ext_req_sync && !ext_req_prev_ff && cp_sync) |=> ext_denied_ff && ext_rdata_ff == 14'h0000)
    else $error("protected memory exposed to programmer");

endmodule : nv_memory_access_control

`default_nettype wire

// ---- tb/nv_memory_access_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module nv_memory_access_control_test
  import nv_access_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic por = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [1:0] guard_pins = GUARD_OFF;
  logic code_protect_pin = 1'b0;
  logic ext_read_req_pin = 1'b0;
  logic ext_space_pin = 1'b0;
  logic [14:0] ext_addr_pins = 15'h00FF;
  logic [31:0] readdata_ff;
  logic waitrequest_ff;
  logic irq_ff;
  logic [13:0] ext_rdata_ff;
  logic ext_denied_ff;
  logic ext_valid_ff;
  int mismatches = 0;
  int check_count = 0;
  logic [32:0] notes[$];
  logic [14:0] ext_notes[$];
  logic [32:0] e;
  logic [14:0] x;
  logic [7:0] rd;
  logic [7:0] dl;
  logic [5:0] dh;

  always #25 mclk = ~mclk;

  nv_memory_access_control uut (
    .mclk(mclk), .reset(reset), .por(por), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata_ff(readdata_ff),
    .waitrequest_ff(waitrequest_ff), .irq_ff(irq_ff), .guard_pins(guard_pins),
    .code_protect_pin(code_protect_pin), .ext_read_req_pin(ext_read_req_pin),
    .ext_space_pin(ext_space_pin), .ext_addr_pins(ext_addr_pins),
    .ext_rdata_ff(ext_rdata_ff), .ext_denied_ff(ext_denied_ff), .ext_valid_ff(ext_valid_ff)
  );

  // ----------------------------------------
  // Comparison and verdict
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results();
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Bus and operation tasks
  // ----------------------------------------
  // Request held until waitrequest is seen low; one spare edge avoids double drive
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [32:0] n);
    if (!w) notes.push_back(n);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {24'h000000, d};
    do begin
      @(posedge mclk);
    end while (waitrequest_ff !== 1'b0);
    rd = readdata_ff[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 33'h000000000);
  endtask : wr

  task automatic chk(input logic [5:0] a, input logic [7:0] d);
    bus(1'b0, a, 8'h00, {9'h100, 16'h0000, d});
  endtask : chk

  // Unchecked reads of control until both start bits drop
  task automatic poll();
    rd = 8'h03;
    while (rd[1:0] !== 2'b00) begin
      bus(1'b0, OFS_CONTROL, 8'h00, 33'h000000000);
    end
  endtask : poll

  // Pointer and data must precede the key: any other write disarms it
  task automatic nvwrite(input logic sp, input logic [6:0] ah, input logic [7:0] al,
                         input logic [13:0] wd);
    wr(OFS_ADDR_LOW, al);
    wr(OFS_ADDR_HIGH, {1'b0, ah});
    wr(OFS_DATA_LOW, wd[7:0]);
    wr(OFS_DATA_HIGH, {2'b00, wd[13:8]});
    wr(OFS_CONTROL, {sp, 7'h04});
    wr(OFS_UNLOCK, UNLOCK_KEY_ONE);
    wr(OFS_UNLOCK, UNLOCK_KEY_TWO);
    wr(OFS_CONTROL, {sp, 7'h06});
  endtask : nvwrite

  task automatic nvread(input logic sp, input logic [6:0] ah, input logic [7:0] al);
    wr(OFS_ADDR_LOW, al);
    wr(OFS_ADDR_HIGH, {1'b0, ah});
    wr(OFS_DATA_LOW, 8'h00);
    wr(OFS_DATA_HIGH, 8'h00);
    wr(OFS_CONTROL, {sp, 7'h01});
    poll();
  endtask : nvread

  // Interrupt level lags its cause by one registered stage
  task automatic irqis(input logic exp);
    repeat (2) @(posedge mclk);
    check("irq_ff", {31'h00000000, irq_ff}, {31'h00000000, exp});
  endtask : irqis

  task automatic ext(input logic cp, input logic [14:0] xp);
    code_protect_pin <= cp;
    ext_notes.push_back(xp);
    repeat (4) @(posedge mclk);
    ext_read_req_pin <= 1'b1;
    do begin
      @(posedge mclk);
    end while (ext_valid_ff !== 1'b1);
    ext_read_req_pin <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : ext

  // ----------------------------------------
  // Result monitor: oldest note against each answer
  // ----------------------------------------
  always @(posedge mclk) begin
    if (read === 1'b1 && waitrequest_ff === 1'b0 && notes.size() > 0) begin
      e = notes.pop_front();
      if (e[32]) check("readdata", readdata_ff, e[31:0]);
    end
    if (ext_valid_ff === 1'b1 && ext_notes.size() > 0) begin
      x = ext_notes.pop_front();
      check("ext_read", {17'h00000, ext_denied_ff, ext_rdata_ff}, {17'h00000, x});
    end
  end

  // Generous bound: the sequence needs under a thousand cycles
  initial begin
    #2000000;
    mismatches++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hCF6C9ECC));
    // Bits 7 and 0 forced high, bit 6 low, so neither the byte nor its inverse equals an erased or zero cell
    dl = (8'($urandom) | 8'h81) & 8'hBF;
    dh = 6'($urandom);
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge mclk);
    chk(OFS_CONTROL, 8'h00);
    wr(OFS_UNLOCK, UNLOCK_KEY_ONE);
    chk(OFS_UNLOCK, 8'h00);
    wr(6'h24, 8'hFF);
    chk(6'h24, 8'h00);
    byteenable <= 4'h0;
    wr(OFS_IRQ_MASK_TWO, 8'hFF);
    byteenable <= 4'hF;
    chk(OFS_IRQ_MASK_TWO, MASK_RESET);
    wr(OFS_IRQ_MASK_TWO, 8'hFF);
    chk(OFS_IRQ_MASK_TWO, MASK_IMPL);
    // Start without key, then key without prior permit
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_CONTROL, 8'h06);
    chk(OFS_CONTROL, 8'h04);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_UNLOCK, UNLOCK_KEY_ONE);
    wr(OFS_UNLOCK, UNLOCK_KEY_TWO);
    wr(OFS_CONTROL, 8'h06);
    chk(OFS_CONTROL, 8'h04);
    // Data byte at the top address; high pointer byte is noise here
    nvwrite(1'b0, 7'h2A, 8'hFF, {6'h15, dl});
    chk(OFS_CONTROL, 8'h06);
    wr(OFS_CONTROL, 8'h04);
    chk(OFS_CONTROL, 8'h06);
    poll();
    chk(OFS_CONTROL, 8'h04);
    irqis(1'b0);
    wr(OFS_IRQ_CONTROL, 8'h40);
    irqis(1'b1);
    wr(OFS_IRQ_MASK_TWO, 8'h00);
    irqis(1'b0);
    wr(OFS_IRQ_MASK_TWO, 8'h10);
    irqis(1'b1);
    chk(OFS_IRQ_FLAG_TWO, 8'h10);
    wr(OFS_IRQ_FLAG_TWO, 8'h10);
    chk(OFS_IRQ_FLAG_TWO, 8'h00);
    irqis(1'b0);
    nvread(1'b0, 7'h00, 8'hFF);
    chk(OFS_DATA_LOW, dl);
    ext(1'b1, 15'h4000);
    ext(1'b0, {7'h00, dl});
    // Program word at the highest address
    nvwrite(1'b1, 7'h7F, 8'hFF, {dh, dl});
    poll();
    nvread(1'b1, 7'h7F, 8'hFF);
    chk(OFS_DATA_LOW, dl);
    chk(OFS_DATA_HIGH, {2'b00, dh});
    nvwrite(1'b1, 7'h01, 8'h00, {~dh, ~dl});
    poll();
    guard_pins <= GUARD_LOW;
    repeat (4) @(posedge mclk);
    nvwrite(1'b1, 7'h01, 8'h00, 14'h0000);
    chk(OFS_CONTROL, 8'h84);
    nvread(1'b1, 7'h01, 8'h00);
    chk(OFS_DATA_LOW, ~dl);
    // Space switched to program by the start write itself
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_UNLOCK, UNLOCK_KEY_ONE);
    wr(OFS_UNLOCK, UNLOCK_KEY_TWO);
    wr(OFS_CONTROL, 8'h86);
    chk(OFS_CONTROL, 8'h84);
    guard_pins <= GUARD_HALF;
    repeat (4) @(posedge mclk);
    nvwrite(1'b1, 7'h0F, 8'hFF, 14'h0000);
    chk(OFS_CONTROL, 8'h84);
    guard_pins <= 2'h0;
    repeat (4) @(posedge mclk);
    nvwrite(1'b1, 7'h1F, 8'hFF, 14'h0000);
    chk(OFS_CONTROL, 8'h84);
    guard_pins <= GUARD_LOW;
    repeat (4) @(posedge mclk);
    // Reset in mid-erase must leave the abort mark
    nvwrite(1'b1, 7'h03, 8'h00, 14'h0033);
    repeat (10) @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk(OFS_CONTROL, 8'h08);
    por <= 1'b1;
    repeat (2) @(posedge mclk);
    por <= 1'b0;
    @(posedge mclk);
    chk(OFS_CONTROL, 8'h00);
    repeat (4) @(posedge mclk);
    results();
  end
endmodule : nv_memory_access_control_test

`default_nettype wire
